//--- clock_source_pkg.sv
// shared constants and carriers for the core clock source selector
// assumes one 20 MHz system clock; the external clock and strap are pins
package clock_source_pkg;

  // system clock period
  localparam int SYS_CLOCK_PERIOD_NS = 50;

  // internal oscillator model: one tick every so many system cycles
  localparam int PLL_OSC_DIV = 2;
  localparam int PLL_CNT_W = 2;
  localparam logic [PLL_CNT_W-1:0] PLL_CNT_RESET = 2'h0;
  localparam logic [PLL_CNT_W-1:0] PLL_CNT_LAST = PLL_CNT_W'(PLL_OSC_DIV - 1);

  // instruction phase counter
  localparam int PHASE_W = 2;
  localparam logic [PHASE_W-1:0] PHASE_RESET = 2'h0;
  localparam logic [PHASE_W-1:0] PHASE_STEP = 2'h1;

  // halved clock level after reset
  localparam logic HALF_CLK_RESET = 1'h0;

  // synchroniser depth for pin inputs
  localparam int SYNC_STAGES = 2;
  localparam int PIN_COUNT = 2;
  localparam int PIN_EXT_CLK = 0;
  localparam int PIN_STRAP = 1;

  typedef struct packed {
    logic pll_enable_bit;
  } pll_control_register_s;

  typedef struct packed {
    logic half_clk;
    logic [PHASE_W-1:0] phase;
  } instr_clock_s;

endpackage

//--- pin_sync.sv
// two flip-flop synchroniser for a group of pin inputs
// assumes the pins are asynchronous to clk_in
`timescale 1ns/1ps
module pin_sync
#(
  parameter int WIDTH = clock_source_pkg::PIN_COUNT
)
(
  input wire logic clk_in,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] stable_q;

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++)
    begin : g_bit
      // first stage feeds only the second
      always_ff @(posedge clk_in)
      begin
        meta_q[i] <= async_in[i];
        stable_q[i] <= meta_q[i];
      end
    end
  endgenerate

  assign sync_out = stable_q;

endmodule

//--- core_clock_select.sv
// core clock source selector: oscillator or external clock, halved to phases
// assumes CLOCK_IN is the only clock; external clock and strap are async pins
`timescale 1ns/1ps
module core_clock_select
(
  input wire logic CLOCK_IN,
  input wire logic SYS_RST_IN,
  input wire logic EXTERNAL_CLOCK_INPUT_IN,
  input wire logic PLL_INIT_STRAP_PIN_IN,
  output logic PLL_ENABLE_OUT,
  output logic INSTR_CLOCK_OUT,
  output logic [clock_source_pkg::PHASE_W-1:0] PHASE_OUT,
  output logic PHASE_TICK_OUT
);

  logic [clock_source_pkg::PIN_COUNT-1:0] pins_sync;
  logic ext_clk_sync;
  logic strap_sync;
  logic ext_prev_q;
  logic ext_prev_d;
  logic ext_tick;

  clock_source_pkg::pll_control_register_s pll_control_register_q;
  clock_source_pkg::pll_control_register_s pll_control_register_d;
  logic [clock_source_pkg::PLL_CNT_W-1:0] pll_cnt_q;
  logic [clock_source_pkg::PLL_CNT_W-1:0] pll_cnt_d;
  logic pll_tick;
  logic src_tick;

  clock_source_pkg::instr_clock_s clk_q;
  clock_source_pkg::instr_clock_s clk_d;
  logic phase_tick_q;
  logic phase_tick_d;

  // pin synchronisers
  pin_sync #(
    .WIDTH(clock_source_pkg::PIN_COUNT)
  ) u_pin_sync (
    .clk_in(CLOCK_IN),
    .async_in({PLL_INIT_STRAP_PIN_IN, EXTERNAL_CLOCK_INPUT_IN}),
    .sync_out(pins_sync)
  );

  assign ext_clk_sync = pins_sync[clock_source_pkg::PIN_EXT_CLK];
  assign strap_sync = pins_sync[clock_source_pkg::PIN_STRAP];

  // external clock rising edge
  always_comb
  begin
    ext_prev_d = ext_clk_sync;
  end

  assign ext_tick = ext_clk_sync & ~ext_prev_q;

  // enable bit: strap captured only during reset
  always_comb
  begin
    pll_control_register_d = pll_control_register_q;
    if (SYS_RST_IN)
    begin
      pll_control_register_d.pll_enable_bit = strap_sync;
    end
    else
    begin
      pll_control_register_d = pll_control_register_q;
    end
  end

  // oscillator model, ticks once every PLL_OSC_DIV system cycles when enabled, independent of the external clock
  always_comb
  begin
    pll_cnt_d = pll_cnt_q;
    if (SYS_RST_IN || !pll_control_register_q.pll_enable_bit)
    begin
      pll_cnt_d = clock_source_pkg::PLL_CNT_RESET;
    end
    else if (pll_cnt_q == clock_source_pkg::PLL_CNT_LAST)
    begin
      pll_cnt_d = clock_source_pkg::PLL_CNT_RESET;
    end
    else
    begin
      pll_cnt_d = pll_cnt_q + clock_source_pkg::PLL_CNT_W'(1);
    end
  end

  assign pll_tick = pll_control_register_q.pll_enable_bit &&
                    (pll_cnt_q == clock_source_pkg::PLL_CNT_LAST);

  // source select
  assign src_tick = pll_control_register_q.pll_enable_bit ? pll_tick : ext_tick;

  // halving and phase counting
  always_comb
  begin
    clk_d = clk_q;
    phase_tick_d = 1'b0;
    if (SYS_RST_IN)
    begin
      clk_d.half_clk = clock_source_pkg::HALF_CLK_RESET;
      clk_d.phase = clock_source_pkg::PHASE_RESET;
    end
    else if (src_tick)
    begin
      clk_d.half_clk = ~clk_q.half_clk;
      clk_d.phase = clk_q.phase + clock_source_pkg::PHASE_STEP;
      phase_tick_d = 1'b1;
    end
  end

  always_ff @(posedge CLOCK_IN)
  begin
    ext_prev_q <= ext_prev_d;
    pll_control_register_q <= pll_control_register_d;
    pll_cnt_q <= pll_cnt_d;
    clk_q <= clk_d;
    phase_tick_q <= phase_tick_d;
  end

  // only enable, phase, phase pulse and cycle clock leave the block; no lock or core clock
  assign PLL_ENABLE_OUT = pll_control_register_q.pll_enable_bit;
  assign INSTR_CLOCK_OUT = clk_q.half_clk;
  assign PHASE_OUT = clk_q.phase;
  assign PHASE_TICK_OUT = phase_tick_q;

  // checks
  sequence osc_gap_s;
    !pll_tick ##1 pll_tick;
  endsequence

  sequence half_toggle_s;
    ##1 (clk_q.half_clk != $past(clk_q.half_clk));
  endsequence

  sequence cycle_fall_s;
    ##2 $fell(INSTR_CLOCK_OUT);
  endsequence

  // synchroniser holds a known strap only after two reset edges
  chk_strap_capture: assert property (
    @(posedge CLOCK_IN) (SYS_RST_IN && $past(SYS_RST_IN, 2)) |=>
    (PLL_ENABLE_OUT == $past(strap_sync)))
    else $error("enable bit did not follow strap during reset");

  chk_strap_ignored: assert property (
    @(posedge CLOCK_IN) (!SYS_RST_IN ##1 !SYS_RST_IN) |-> $stable(PLL_ENABLE_OUT))
    else $error("enable bit changed after reset release");

  chk_osc_source: assert property (
    @(posedge CLOCK_IN) disable iff (SYS_RST_IN)
    (PLL_ENABLE_OUT && pll_tick) |-> half_toggle_s)
    else $error("oscillator tick did not toggle cycle clock");

  chk_osc_cadence: assert property (
    @(posedge CLOCK_IN) disable iff (SYS_RST_IN)
    (PLL_ENABLE_OUT && pll_tick) |=> osc_gap_s)
    else $error("oscillator tick spacing wrong");

  chk_osc_stopped: assert property (
    @(posedge CLOCK_IN) !PLL_ENABLE_OUT |-> (!pll_tick && pll_cnt_q == 2'h0))
    else $error("oscillator running while disabled");

  chk_ext_halve: assert property (
    @(posedge CLOCK_IN) disable iff (SYS_RST_IN)
    (!PLL_ENABLE_OUT && ext_tick) |-> half_toggle_s)
    else $error("external edge did not toggle cycle clock");

  chk_half_hold: assert property (
    @(posedge CLOCK_IN) disable iff (SYS_RST_IN)
    (!src_tick ##1 !SYS_RST_IN) |-> $stable(INSTR_CLOCK_OUT))
    else $error("cycle clock moved without a source tick");

  chk_phase_step: assert property (
    @(posedge CLOCK_IN) disable iff (SYS_RST_IN)
    $changed(INSTR_CLOCK_OUT) |-> (PHASE_OUT == $past(PHASE_OUT) + 2'h1) && PHASE_TICK_OUT)
    else $error("phase did not step with cycle clock edge");

  chk_phase_reset: assert property (
    @(posedge CLOCK_IN) SYS_RST_IN |=> (PHASE_OUT == 2'h0 && !INSTR_CLOCK_OUT))
    else $error("phase not cleared by reset");

  chk_ext_ignored: assert property (
    @(posedge CLOCK_IN) disable iff (SYS_RST_IN)
    (PLL_ENABLE_OUT && ext_tick && !pll_tick) |=> $stable(INSTR_CLOCK_OUT))
    else $error("external edge moved cycle clock while oscillator selected");

  chk_osc_first: assert property (
    @(posedge CLOCK_IN) disable iff (SYS_RST_IN)
    (PLL_ENABLE_OUT && $fell(SYS_RST_IN)) |=> pll_tick)
    else $error("oscillator did not start after reset release");

  chk_cycle_period: assert property (
    @(posedge CLOCK_IN) disable iff (SYS_RST_IN)
    (PLL_ENABLE_OUT && $rose(INSTR_CLOCK_OUT)) |-> cycle_fall_s)
    else $error("cycle clock high phase length wrong");

  chk_ext_single: assert property (
    @(posedge CLOCK_IN) disable iff (SYS_RST_IN)
    (!PLL_ENABLE_OUT && ext_tick) |=> PHASE_TICK_OUT)
    else $error("external edge gave no phase pulse");

  chk_tick_phase: assert property (
    @(posedge CLOCK_IN) disable iff (SYS_RST_IN)
    PHASE_TICK_OUT |-> $changed(PHASE_OUT))
    else $error("phase pulse without phase step");

  chk_tick_single: assert property (
    @(posedge CLOCK_IN) disable iff (SYS_RST_IN)
    PHASE_TICK_OUT |=> !PHASE_TICK_OUT)
    else $error("phase pulse lasted more than one cycle");

  chk_tick_reset: assert property (
    @(posedge CLOCK_IN) SYS_RST_IN |=> !PHASE_TICK_OUT)
    else $error("phase pulse not cleared by reset");

endmodule

//--- ext_clock_model.sv
// external clock oscillator model for the core clock selector
// assumes level lengths of at least 3 cycles come from the bench
`timescale 1ns/1ps
module ext_clock_model
(
  input wire logic clk_in,
  input wire logic run_in,
  input wire logic [2:0] level_len_in,
  output logic ext_clk_out,
  output logic [15:0] rise_count_out
);
  int left;
  initial
  begin
    ext_clk_out = 1'b0;
    rise_count_out = 16'h0;
    left = 2;
  end
  // stops at the end of the current level, finishing any high level, then holds low
  always @(posedge clk_in)
  begin
    #2;
    if (left > 1)
      left = left - 1;
    else if (run_in || ext_clk_out)
    begin
      ext_clk_out = ~ext_clk_out;
      left = level_len_in;
      if (ext_clk_out)
        rise_count_out = rise_count_out + 16'h1;
    end
  end
endmodule

//--- test_core_clock_select.sv
// random self-checking bench for the core clock selector
// assumes the oscillator ticks every two cycles when enabled
`timescale 1ns/1ps
module test_core_clock_select;
  logic clk, rst, strap, run, ext, pll_en, instr_clk, tick, s, exp_clk;
  logic [2:0] len;
  logic [15:0] rises, ticks, r0;
  logic [clock_source_pkg::PHASE_W-1:0] phase, exp_phase;
  int mismatches = 0;
  int compares = 0;
  int seed = 32'hf7798dd1;
  core_clock_select dut_u (.CLOCK_IN(clk), .SYS_RST_IN(rst), .EXTERNAL_CLOCK_INPUT_IN(ext),
    .PLL_INIT_STRAP_PIN_IN(strap), .PLL_ENABLE_OUT(pll_en), .INSTR_CLOCK_OUT(instr_clk),
    .PHASE_OUT(phase), .PHASE_TICK_OUT(tick));
  ext_clock_model osc_u (.clk_in(clk), .run_in(run), .level_len_in(len),
    .ext_clk_out(ext), .rise_count_out(rises));
  initial clk = 1'b0;
  always #25 clk = ~clk;
  function automatic logic [15:0] exp_ticks(input int cycles);
    return 16'((cycles + clock_source_pkg::PLL_OSC_DIV - 1) / clock_source_pkg::PLL_OSC_DIV);
  endfunction
  task automatic check_bit(input string what, input logic e, input logic g);
    compares++;
    if (g !== e)
    begin
      mismatches++;
      $display("[ERR] %s expected %b seen %b", what, e, g);
    end
  endtask
  task automatic check_val(input string what, input logic [15:0] e, input logic [15:0] g);
    compares++;
    if (g !== e)
    begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic report_and_stop;
    if (mismatches == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // expected phase and cycle clock follow every tick
  always @(negedge clk)
  begin
    if (rst)
    begin
      exp_phase = clock_source_pkg::PHASE_RESET;
      exp_clk = clock_source_pkg::HALF_CLK_RESET;
    end
    else if (tick === 1'b1)
    begin
      exp_phase = exp_phase + clock_source_pkg::PHASE_STEP;
      exp_clk = ~exp_clk;
      ticks = ticks + 16'h1;
      check_val("phase", 16'(exp_phase), 16'(phase));
      check_bit("instr_clk", exp_clk, instr_clk);
    end
  end
  task automatic do_reset(input logic sv);
    strap = sv;
    repeat (3) @(posedge clk);
    #2 rst = 1'b1;
    repeat (3) @(posedge clk);
    #2;
    check_bit("pll_en", sv, pll_en);
    check_bit("instr_clk", 1'b0, instr_clk);
    check_val("phase", 16'h0, 16'(phase));
    rst = 1'b0;
  endtask
  task automatic run_case(input logic sv);
    for (int i = 0; i < 60; i++)
    begin
      if (i == 4)
      begin
        ticks = 16'h0;
        r0 = rises;
        run = 1'b1;
      end
      @(posedge clk);
      #2 strap = $random(seed);
      len = 3'(3 + {$random(seed)} % 4);
    end
    @(negedge clk);
    #1;
    if (sv)
      check_val("osc_ticks", exp_ticks(57), ticks);
    run = 1'b0;
    repeat (20) @(posedge clk);
    #2;
    if (!sv)
      check_val("ext_ticks", rises - r0, ticks);
    check_bit("pll_en", sv, pll_en);
  endtask
  initial
  begin
    rst = 1'b1;
    strap = 1'b0;
    run = 1'b0;
    len = 3'h3;
    ticks = 16'h0;
    r0 = 16'h0;
    for (int i = 0; i < 8; i++)
    begin
      s = (i < 2) ? i[0] : 1'($random(seed));
      do_reset(s);
      run_case(s);
    end
    report_and_stop;
  end
  initial
  begin
    #250000;
    mismatches++;
    report_and_stop;
  end
endmodule
